// File: bsl_consts.svh
`ifndef BSL_CONSTS_SVH
`define BSL_CONSTS_SVH

// flash geometry in words, and boot section size per boot_size_fuse code
`define BSL_FLASH_WORDS 14'h2000
`define BSL_BOOT_WORDS_0 14'h0400
`define BSL_BOOT_WORDS_1 14'h0200
`define BSL_BOOT_WORDS_2 14'h0100
`define BSL_BOOT_WORDS_3 14'h0080
`define BSL_APP_RESET 13'h0000

// register byte offsets
`define BSL_OFF_LOCK 8'h00
`define BSL_OFF_FUSE 8'h04
`define BSL_OFF_STAT 8'h08

// lock byte fields, 1 = unprogrammed
`define BSL_APP_STORE 0
`define BSL_APP_LOAD 1
`define BSL_BOOT_STORE 2
`define BSL_BOOT_LOAD 3
`define BSL_GEN_LOCK_LO 4
`define BSL_GEN_LOCK_HI 5
`define BSL_LOCK_ERASED 8'hFF

// status fields
`define BSL_ST_STORE_BLK 0
`define BSL_ST_LOAD_BLK 1
`define BSL_ST_RST 2'h0

`define BSL_RESP_OKAY 2'h0
`define BSL_RESP_SLVERR 2'h2

`endif

// File: bsl_pkg.sv
package bsl_pkg;

	typedef logic [12:0] bsl_word_t;

	// one program-memory access from the core; addr is a byte address
	typedef struct packed {
		logic valid;
		logic [13:0] addr;
	} bsl_acc_s;

	typedef enum logic {
		BSL_SECT_APP,
		BSL_SECT_BOOT
	} bsl_sect_e;

endpackage : bsl_pkg

// File: bsl_guard.sv
`timescale 1ns/1ns
`include "bsl_consts.svh"
// How it works
// - app lock 11: app accesses unrestricted
// - app store lock programmed: block app stores
// - app load lock: block boot-code loads of app
// - app modes 3,4: mask irqs in app
// - boot lock 11: boot accesses unrestricted
// - boot store lock programmed: block boot stores
// - boot load lock: block app-code loads of boot
// - boot modes 3,4: mask irqs in boot
// - lock bits only erased to 1 by chip erase
// - general write lock ignores stores; here the general lock bits are stored but gate no store
// - general read/write lock ignores loads, stores; here the general lock bits gate no load or store
// - reset vector chosen by boot reset fuse
// - core can never alter fuses
// - boot size fuse sets section boundary
// - stores start programming only from boot code
module bsl_guard import bsl_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] nv_lock_image,
	input wire logic prog_lock_wr,
	input wire logic [7:0] prog_lock_data,
	input wire logic chip_erase,
	input wire logic boot_reset_vector_fuse,
	input wire logic [1:0] boot_size_fuse,
	input wire bsl_word_t pc,
	input wire logic vectors_in_boot,
	input wire bsl_acc_s store_req,
	output logic store_allow,
	input wire bsl_acc_s load_req,
	output logic load_allow,
	output logic irq_mask,
	output logic flash_store_go,
	output bsl_word_t flash_store_addr,
	output bsl_word_t reset_vector
);

	logic [13:0] boot_words;
	logic [13:0] app_words;
	bsl_sect_e pc_sect;
	bsl_sect_e st_sect;
	bsl_sect_e ld_sect;

	always_comb begin
		unique case (boot_size_fuse)
			2'h0: boot_words = `BSL_BOOT_WORDS_0;
			2'h1: boot_words = `BSL_BOOT_WORDS_1;
			2'h2: boot_words = `BSL_BOOT_WORDS_2;
			2'h3: boot_words = `BSL_BOOT_WORDS_3;
		endcase
		app_words = `BSL_FLASH_WORDS - boot_words;
		// word compares; load and store addresses are bytes
		pc_sect = ({1'b0, pc} >= app_words) ? BSL_SECT_BOOT : BSL_SECT_APP;
		st_sect = ({1'b0, store_req.addr[13:1]} >= app_words) ? BSL_SECT_BOOT
			: BSL_SECT_APP;
		ld_sect = ({1'b0, load_req.addr[13:1]} >= app_words) ? BSL_SECT_BOOT
			: BSL_SECT_APP;
	end

	logic [7:0] lock_q, lock_d;
	logic [1:0] stat_q, stat_d;
	logic go_q, go_d;
	bsl_word_t go_addr_q, go_addr_d;
	bsl_word_t rv_q, rv_d;
	logic st_lock_ok;
	logic ld_blocked;

	// general lock bits are stored but deliberately gate nothing here
	always_comb begin
		st_lock_ok = (st_sect == BSL_SECT_BOOT) ? lock_q[`BSL_BOOT_STORE]
			: lock_q[`BSL_APP_STORE];
		store_allow = store_req.valid && (pc_sect == BSL_SECT_BOOT)
			&& st_lock_ok;
		ld_blocked = ((pc_sect == BSL_SECT_BOOT) && (ld_sect == BSL_SECT_APP)
			&& !lock_q[`BSL_APP_LOAD])
			|| ((pc_sect == BSL_SECT_APP) && (ld_sect == BSL_SECT_BOOT)
			&& !lock_q[`BSL_BOOT_LOAD]);
		load_allow = load_req.valid && !ld_blocked;
		irq_mask = ((pc_sect == BSL_SECT_APP) && vectors_in_boot
			&& !lock_q[`BSL_APP_LOAD])
			|| ((pc_sect == BSL_SECT_BOOT) && !vectors_in_boot
			&& !lock_q[`BSL_BOOT_LOAD]);
	end

	// axi write channel state
	logic aw_have_q, aw_have_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic w_have_q, w_have_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic wr_fire;
	logic wr_lock;
	logic wr_stat;

	always_comb begin
		s_axi_awready = !aw_have_q;
		s_axi_wready = !w_have_q;
		wr_fire = aw_have_q && w_have_q && !bvalid_q;
		wr_lock = wr_fire && (awaddr_q == `BSL_OFF_LOCK) && wstrb_q[0];
		wr_stat = wr_fire && (awaddr_q == `BSL_OFF_STAT) && wstrb_q[0];
		aw_have_d = aw_have_q;
		awaddr_d = awaddr_q;
		w_have_d = w_have_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			// fuse word is read-only to the core, so a write is refused
			bresp_d = ((awaddr_q == `BSL_OFF_LOCK) || (awaddr_q == `BSL_OFF_STAT))
				? `BSL_RESP_OKAY : `BSL_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			w_have_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `BSL_RESP_OKAY;
		end else begin
			aw_have_q <= aw_have_d;
			awaddr_q <= awaddr_d;
			w_have_q <= w_have_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	// axi read channel state
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	always_comb begin
		s_axi_arready = !rvalid_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = `BSL_RESP_OKAY;
			unique case (s_axi_araddr)
				`BSL_OFF_LOCK: rdata_d = {24'h000000, lock_q};
				`BSL_OFF_FUSE: rdata_d = {29'h00000000, boot_size_fuse,
					boot_reset_vector_fuse};
				`BSL_OFF_STAT: rdata_d = {30'h00000000, stat_q};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = `BSL_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `BSL_RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// lock byte: software and programmer can only clear bits (program)
	always_comb begin
		lock_d = lock_q;
		if (wr_lock) begin
			lock_d = lock_d & wdata_q[7:0];
		end
		if (prog_lock_wr) begin
			lock_d = lock_d & prog_lock_data;
		end
		if (chip_erase) begin
			lock_d = `BSL_LOCK_ERASED;
		end
		// sticky block flags, set wins over a write-one clear
		stat_d = stat_q;
		if (wr_stat) begin
			stat_d = stat_d & ~wdata_q[1:0];
		end
		stat_d[`BSL_ST_STORE_BLK] = stat_d[`BSL_ST_STORE_BLK]
			| (store_req.valid && !store_allow);
		stat_d[`BSL_ST_LOAD_BLK] = stat_d[`BSL_ST_LOAD_BLK]
			| (load_req.valid && !load_allow);
		// blocked store simply never reaches the flash, core runs on
		go_d = store_allow;
		go_addr_d = store_allow ? store_req.addr[13:1] : go_addr_q;
		rv_d = boot_reset_vector_fuse ? `BSL_APP_RESET
			: app_words[12:0];
	end

	// lock byte lives in nonvolatile cells, so reset reloads its image
	always_ff @(posedge clock) begin
		if (rst) begin
			lock_q <= nv_lock_image;
			stat_q <= `BSL_ST_RST;
			go_q <= 1'b0;
			go_addr_q <= `BSL_APP_RESET;
			rv_q <= `BSL_APP_RESET;
		end else begin
			lock_q <= lock_d;
			stat_q <= stat_d;
			go_q <= go_d;
			go_addr_q <= go_addr_d;
			rv_q <= rv_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign flash_store_go = go_q;
	assign flash_store_addr = go_addr_q;
	assign reset_vector = rv_q;

	app_free_a: assert property (@(posedge clock) disable iff (rst)
		(lock_q[1:0] == 2'h3 && load_req.valid && ld_sect == BSL_SECT_APP)
		|-> load_allow)
		else $error("app load refused with app locks open");

	boot_free_a: assert property (@(posedge clock) disable iff (rst)
		(lock_q[3:2] == 2'h3 && load_req.valid && ld_sect == BSL_SECT_BOOT)
		|-> load_allow)
		else $error("boot load refused with boot locks open");

	app_store_a: assert property (@(posedge clock) disable iff (rst)
		(!lock_q[`BSL_APP_STORE] && st_sect == BSL_SECT_APP) |=> !go_q)
		else $error("store reached locked app section");

	app_load_a: assert property (@(posedge clock) disable iff (rst)
		(!lock_q[`BSL_APP_LOAD] && pc_sect == BSL_SECT_BOOT
		&& ld_sect == BSL_SECT_APP) |-> !load_allow)
		else $error("boot code read locked app section");

	app_irq_a: assert property (@(posedge clock) disable iff (rst)
		(!lock_q[`BSL_APP_LOAD] && vectors_in_boot && pc_sect == BSL_SECT_APP)
		|-> irq_mask)
		else $error("irq not masked in app section");

	boot_store_a: assert property (@(posedge clock) disable iff (rst)
		(!lock_q[`BSL_BOOT_STORE] && st_sect == BSL_SECT_BOOT) |=> !go_q)
		else $error("store reached locked boot section");

	boot_load_a: assert property (@(posedge clock) disable iff (rst)
		(!lock_q[`BSL_BOOT_LOAD] && pc_sect == BSL_SECT_APP
		&& ld_sect == BSL_SECT_BOOT) |-> !load_allow)
		else $error("app code read locked boot section");

	boot_irq_a: assert property (@(posedge clock) disable iff (rst)
		(!lock_q[`BSL_BOOT_LOAD] && !vectors_in_boot && pc_sect == BSL_SECT_BOOT)
		|-> irq_mask)
		else $error("irq not masked in boot section");

	lock_sticky_a: assert property (@(posedge clock) disable iff (rst)
		(!chip_erase) |=> ((lock_q & ~$past(lock_q)) == 8'h00))
		else $error("lock bit unprogrammed without erase");

	erase_lock_a: assert property (@(posedge clock) disable iff (rst)
		chip_erase |=> (lock_q == `BSL_LOCK_ERASED))
		else $error("chip erase did not clear locks");

	reset_vec_a: assert property (@(posedge clock) disable iff (rst)
		boot_reset_vector_fuse |=> (reset_vector == `BSL_APP_RESET))
		else $error("reset vector wrong for unprogrammed fuse");

	reset_boot_a: assert property (@(posedge clock) disable iff (rst)
		!boot_reset_vector_fuse
		|=> (reset_vector == $past(app_words[12:0])))
		else $error("reset vector not at boot start");

	fuse_ro_a: assert property (@(posedge clock) disable iff (rst)
		(wr_fire && awaddr_q == `BSL_OFF_FUSE)
		|=> (s_axi_bresp == `BSL_RESP_SLVERR))
		else $error("fuse write not refused");

	app_pc_a: assert property (@(posedge clock) disable iff (rst)
		(store_req.valid && pc_sect == BSL_SECT_APP) |=> !go_q ##1 1'b1)
		else $error("store from app code started programming");

	blk_flag_a: assert property (@(posedge clock) disable iff (rst)
		(store_req.valid && !store_allow) |=> stat_q[`BSL_ST_STORE_BLK])
		else $error("blocked store not flagged");

	bresp_wait_a: assert property (@(posedge clock) disable iff (rst)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
		else $error("write response dropped early");

	store_go_c: cover property (@(posedge clock) disable iff (rst)
		store_allow ##1 flash_store_go);
	load_blk_c: cover property (@(posedge clock) disable iff (rst)
		load_req.valid && ld_blocked);
	irq_mask_c: cover property (@(posedge clock) disable iff (rst)
		irq_mask);
	lock_wr_c: cover property (@(posedge clock) disable iff (rst)
		wr_lock ##1 (lock_q != $past(lock_q)));

endmodule : bsl_guard

// File: bsl_core_model.sv
`timescale 1ns/1ns
module bsl_core_model import bsl_pkg::*; (
	input wire logic clock,
	output bsl_word_t pc,
	output bsl_acc_s store_req,
	output bsl_acc_s load_req
);
	initial begin
		pc = 13'h0000;
		store_req = '0;
		load_req = '0;
	end
	// called right after a rising edge, so every change lands off the sampling edge
	task automatic issue(input bsl_word_t p, input logic [13:0] sa, input logic [13:0] la);
		pc <= p;
		store_req <= {1'b1, sa};
		load_req <= {1'b1, la};
	endtask : issue
	// address lines are not kept when idle: invert so stale values never look valid
	task automatic idle;
		store_req <= {1'b0, ~store_req.addr};
		load_req <= {1'b0, ~load_req.addr};
	endtask : idle
endmodule : bsl_core_model

// File: tb.sv
`timescale 1ns/1ns
`include "bsl_consts.svh"
module tb import bsl_pkg::*; ();
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr, s_axi_araddr, nv_lock_image, prog_lock_data;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, boot_size_fuse;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, prog_lock_wr, chip_erase;
	logic boot_reset_vector_fuse, vectors_in_boot, store_allow, load_allow, irq_mask;
	logic flash_store_go;
	bsl_word_t pc, flash_store_addr, reset_vector;
	bsl_acc_s store_req, load_req;
	int num_errors = 0;
	int check_count = 0;

	always #10 clock = ~clock;

	bsl_guard dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .nv_lock_image, .prog_lock_wr, .prog_lock_data, .chip_erase,
		.boot_reset_vector_fuse, .boot_size_fuse, .pc, .vectors_in_boot, .store_req, .store_allow,
		.load_req, .load_allow, .irq_mask, .flash_store_go, .flash_store_addr, .reset_vector);
	bsl_core_model core (.clock, .pc, .store_req, .load_req);

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xorshift

	function automatic bsl_word_t boundary(input logic [1:0] sz);
		logic [13:0] b;
		b = 14'h2000 - (14'h0400 >> sz);
		return b[12:0];
	endfunction : boundary

	// bit0 store allowed, bit1 load allowed, bit2 interrupts masked
	function automatic logic [2:0] expect_acc(input bsl_word_t p, input logic [13:0] sa,
		input logic [13:0] la, input logic [7:0] lk, input logic [1:0] sz, input logic vb);
		logic pb, sb, lb;
		pb = p >= boundary(sz);
		sb = sa[13:1] >= boundary(sz);
		lb = la[13:1] >= boundary(sz);
		expect_acc[0] = pb && (sb ? lk[2] : lk[0]);
		expect_acc[1] = (pb == lb) || (lb ? lk[3] : lk[1]);
		expect_acc[2] = pb ? (!lk[3] && !vb) : (!lk[1] && vb);
	endfunction : expect_acc

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] sb,
		output logic [1:0] resp);
		int n;
		logic aw, w, tk_aw, tk_w, tk_b;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= sb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		resp = 2'h3;
		n = 0;
		// judge handshakes at the falling edge: settled, and what the next rise samples
		do begin
			@(negedge clock);
			tk_aw = aw && s_axi_awready === 1'b1;
			tk_w = w && s_axi_wready === 1'b1;
			tk_b = s_axi_bvalid === 1'b1;
			if (tk_b) resp = s_axi_bresp;
			@(posedge clock);
			n++;
			if (tk_aw) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (tk_w) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (!tk_b && n < 100);
		if (n >= 100) num_errors++;
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic read_expect(input logic [7:0] a, input logic [31:0] want, input logic [1:0] wr);
		int n;
		logic ar, tk_ar, tk_r;
		logic [31:0] d;
		logic [1:0] rr;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		ar = 1'b1;
		d = 32'hFFFFFFFF;
		rr = 2'h3;
		n = 0;
		do begin
			@(negedge clock);
			tk_ar = ar && s_axi_arready === 1'b1;
			tk_r = s_axi_rvalid === 1'b1;
			if (tk_r) begin
				d = s_axi_rdata;
				rr = s_axi_rresp;
			end
			@(posedge clock);
			n++;
			if (tk_ar) begin
				ar = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end while (!tk_r && n < 100);
		if (n >= 100) num_errors++;
		check("rdata", d, want);
		check("rresp", rr, wr);
		s_axi_rready <= 1'b0;
	endtask : read_expect

	// erase first: programming can only clear bits, so this gives the exact pattern
	task automatic set_lock(input logic [7:0] lk);
		@(posedge clock);
		chip_erase <= 1'b1;
		@(posedge clock);
		chip_erase <= 1'b0;
		prog_lock_wr <= 1'b1;
		prog_lock_data <= lk;
		@(posedge clock);
		prog_lock_wr <= 1'b0;
	endtask : set_lock

	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		summarize();
	end

	initial begin
		logic [31:0] r;
		logic [13:0] sa, la;
		logic [2:0] e;
		logic [1:0] resp;
		bsl_word_t p;
		logic stb, ldb;
		seed = 32'h2540AA7F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{prog_lock_wr, prog_lock_data, chip_erase, boot_reset_vector_fuse} = '0;
		nv_lock_image = 8'hFA;
		boot_size_fuse = 2'h1;
		vectors_in_boot = 1'b0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		check("reset_vector", reset_vector, 13'h1E00);
		read_expect(`BSL_OFF_LOCK, 32'h0000_00FA, `BSL_RESP_OKAY);
		read_expect(`BSL_OFF_FUSE, 32'h0000_0002, `BSL_RESP_OKAY);
		$display("test reset done");
		axi_write(`BSL_OFF_LOCK, 32'hFFFF_FFF7, 4'hF, resp);
		check("bresp", resp, `BSL_RESP_OKAY);
		axi_write(`BSL_OFF_LOCK, 32'h0000_00FF, 4'hF, resp);
		axi_write(`BSL_OFF_LOCK, 32'h0000_0000, 4'h0, resp);
		read_expect(`BSL_OFF_LOCK, 32'h0000_00F2, `BSL_RESP_OKAY);
		axi_write(`BSL_OFF_FUSE, 32'h0000_0000, 4'hF, resp);
		check("bresp", resp, `BSL_RESP_SLVERR);
		read_expect(`BSL_OFF_FUSE, 32'h0000_0002, `BSL_RESP_OKAY);
		read_expect(8'h0C, 32'h0000_0000, `BSL_RESP_SLVERR);
		axi_write(8'h0C, 32'h0000_0000, 4'hF, resp);
		check("bresp", resp, `BSL_RESP_SLVERR);
		set_lock(8'hFF);
		read_expect(`BSL_OFF_LOCK, 32'h0000_00FF, `BSL_RESP_OKAY);
		$display("test registers done");
		stb = 1'b0;
		ldb = 1'b0;
		for (int i = 0; i < 300; i++) begin
			seed = xorshift(seed);
			r = seed;
			set_lock(r[7:0]);
			boot_size_fuse <= r[9:8];
			boot_reset_vector_fuse <= r[10];
			vectors_in_boot <= r[11];
			seed = xorshift(seed);
			p = seed[12:0];
			sa = seed[26:13];
			la = {seed[31:27], seed[8:0]};
			// boundary corners: last app word and first boot word
			if (r[13:12] == 2'h0) p = boundary(r[9:8]) - r[14];
			if (r[17:16] == 2'h0) sa = {boundary(r[9:8]) - r[15], r[18]};
			if (r[20:19] == 2'h0) la = {boundary(r[9:8]) - r[21], r[22]};
			@(posedge clock);
			core.issue(p, sa, la);
			#1;
			e = expect_acc(p, sa, la, r[7:0], r[9:8], r[11]);
			check("store_allow", store_allow, e[0]);
			check("load_allow", load_allow, e[1]);
			check("irq_mask", irq_mask, e[2]);
			check("reset_vector", reset_vector, r[10] ? 13'h0000 : boundary(r[9:8]));
			@(posedge clock);
			core.idle();
			#1;
			check("flash_store_go", flash_store_go, e[0]);
			if (e[0]) check("flash_store_addr", flash_store_addr, sa[13:1]);
			stb |= !e[0];
			ldb |= !e[1];
		end
		read_expect(`BSL_OFF_STAT, {30'h0, ldb, stb}, `BSL_RESP_OKAY);
		axi_write(`BSL_OFF_STAT, 32'h0000_0003, 4'hF, resp);
		read_expect(`BSL_OFF_STAT, 32'h0000_0000, `BSL_RESP_OKAY);
		$display("test access done");
		summarize();
	end
endmodule : tb
